// ===== core/pls_map.svh
// offsets, field positions and timing counts of the led/strap block
// assumes byte addresses on a 32-bit wishbone bus, 200 MHz system clock
`ifndef PLS_MAP_SVH
`define PLS_MAP_SVH
`define PLS_OFS_P1_LED 8'h6C
`define PLS_OFS_P2_LED 8'h84
`define PLS_OFS_CHIP_CFG 8'hD8
`define PLS_OFS_EE_STAT 8'hDC
`define PLS_EE_WIN 3'h7
`define PLS_LED_MODE_HI 14
`define PLS_LED_MODE_LO 12
`define PLS_LED_BSEL_HI 3
`define PLS_LED_BSEL_LO 2
`define PLS_LED_MAN_B 1
`define PLS_LED_MAN_A 0
`define PLS_CFG_WIDTH_HI 7
`define PLS_CFG_WIDTH_LO 6
`define PLS_CFG_EE_PRES 9
`define PLS_CFG_ORDER 10
`define PLS_CFG_RSVD_OK 0
`define PLS_ST_BUSY 0
`define PLS_ST_DONE 1
`define PLS_WIDTH_16 2'h2
`define PLS_WIDTH_8 2'h1
`define PLS_CLK_MHZ 200
`define PLS_BLINK_HALF_MS 125
`define PLS_BLINK_HALF_CYC (`PLS_BLINK_HALF_MS * 1000 * `PLS_CLK_MHZ)
`define PLS_ACT_HOLD 2'h2
`define PLS_EE_SK_HALF_NS 1000
`define PLS_EE_SK_HALF_CYC ((`PLS_EE_SK_HALF_NS * `PLS_CLK_MHZ) / 1000)
`define PLS_EE_WORDS 8
`define PLS_EE_CMD_BITS 9
`define PLS_EE_LAST_BIT 24
`define PLS_EE_READ_OP 3'h6
`endif

// ===== core/pls_pkg.sv
// types shared by the led/strap block and its eeprom reader
// assumes nothing beyond a systemverilog compiler
package pls_pkg;
  typedef enum logic [1:0] {PLS_B_SPEED, PLS_B_DUPLEX, PLS_B_LINK, PLS_B_ACT} pls_bsel_t;
  typedef enum logic [2:0] {PLS_EE_IDLE, PLS_EE_SEL, PLS_EE_SHIFT, PLS_EE_GAP} pls_ee_state_t;
  typedef struct packed {
    logic [2:0] mode;
    pls_bsel_t bsel;
    logic man_b;
    logic man_a;
  } pls_led_ctrl_t;
endpackage

// ===== core/pls_ee_reader.sv
// serial eeprom reader: fetches a fixed number of 16-bit words after start
// assumes a three-wire eeprom answering a read command with msb-first data
`include "pls_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pls_ee_reader (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // control
  input wire logic start,
  output logic busy,
  output logic done,
  // loaded words
  output logic word_valid,
  output logic [2:0] word_idx,
  output logic [15:0] word,
  // eeprom pins
  output logic eeprom_select,
  output logic eeprom_serial_clock,
  output logic data_out,
  output logic data_oe,
  input wire logic data_in
);
  import pls_pkg::*;
  typedef struct packed {
    pls_ee_state_t fsm;
    logic [7:0] div;
    logic sk, cs, dout, doe, wv, busy, done;
    logic [4:0] bitc;
    logic [2:0] addr;
    logic [15:0] sh;
  } pls_ee_st_t;
  pls_ee_st_t st, next_st;
  logic tick;
  logic [8:0] cmd;
  logic [4:0] nb;
  assign tick = st.div == 8'(`PLS_EE_SK_HALF_CYC - 1);
  assign cmd = {`PLS_EE_READ_OP, 3'h0, st.addr};
  assign nb = st.bitc + 5'h1;
  always_comb begin
    next_st = st;
    next_st.wv = 1'b0;
    next_st.div = tick ? 8'h0 : st.div + 8'h1;
    case (st.fsm)
      PLS_EE_IDLE: begin
        if (start) begin
          next_st.fsm = PLS_EE_SEL;
          next_st.addr = 3'h0;
          next_st.busy = 1'b1;
          next_st.done = 1'b0;
          next_st.div = 8'h0;
        end
      end
      PLS_EE_SEL: begin
        if (tick) begin
          next_st.cs = 1'b1;
          next_st.doe = 1'b1;
          next_st.dout = cmd[8];
          next_st.bitc = 5'h0;
          next_st.fsm = PLS_EE_SHIFT;
        end
      end
      PLS_EE_SHIFT: begin
        if (tick && !st.sk) begin
          next_st.sk = 1'b1;
          if (st.bitc >= 5'(`PLS_EE_CMD_BITS))
            next_st.sh = {st.sh[14:0], data_in};
        end else if (tick) begin
          next_st.sk = 1'b0;
          if (st.bitc == 5'(`PLS_EE_LAST_BIT)) begin
            next_st.cs = 1'b0;
            next_st.doe = 1'b0;
            next_st.wv = 1'b1;
            next_st.fsm = PLS_EE_GAP;
          end else begin
            next_st.bitc = nb;
            // command bits go out on the falling clock so they are stable at the rise
            next_st.doe = nb < 5'(`PLS_EE_CMD_BITS);
            next_st.dout = (nb < 5'(`PLS_EE_CMD_BITS)) ? cmd[4'(8 - nb)] : 1'b0;
          end
        end
      end
      PLS_EE_GAP: begin
        if (tick && st.addr == 3'(`PLS_EE_WORDS - 1)) begin
          next_st.fsm = PLS_EE_IDLE;
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
        end else if (tick) begin
          next_st.addr = st.addr + 3'h1;
          next_st.fsm = PLS_EE_SEL;
        end
      end
      default: next_st.fsm = PLS_EE_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign busy = st.busy;
  assign done = st.done;
  assign word_valid = st.wv;
  assign word_idx = st.addr;
  assign word = st.sh;
  assign eeprom_select = st.cs;
  assign eeprom_serial_clock = st.sk;
  assign data_out = st.dout;
  assign data_oe = st.doe;
endmodule
`default_nettype wire

// ===== core/pls_top.sv
// port status leds, strap latching and eeprom load behind a wishbone slave
// assumes the link/speed/duplex/activity inputs are synchronous to clk_sys
// Notes on behaviour
// - led pins are low for on
// - port one field zero gives automatic leds
// - port two field zero gives automatic leds
// - non-zero field hands leds to software
// - link solid, activity blinks, combined on/blink
// - speed led on at 100, off at 10
// - duplex led on full, off half
// - latch bus width from port one pin a
// - latch byte order from port two pin a
// - generate eeprom clock to load configuration
// - drive eeprom select and shared data pin
// - width high is 16-bit, shown bits 7:6
// - order high is little endian, bit 10
// - restrap on reset and on power-down
`include "pls_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pls_top #(
  parameter int unsigned BLINK_HALF_CYC = `PLS_BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // port state, index 0 is port one
  input wire logic [1:0] link_up,
  input wire logic [1:0] activity,
  input wire logic [1:0] speed_100,
  input wire logic [1:0] full_duplex,
  input wire logic power_down,
  input wire logic eeprom_present_strap,
  // led pins, the a pins and port one b pin double as straps
  input wire logic port_one_led_a_in,
  output logic port_one_led_a_out,
  output logic port_one_led_a_oe,
  input wire logic port_one_led_b_in,
  output logic port_one_led_b_out,
  output logic port_one_led_b_oe,
  input wire logic port_two_led_a_in,
  output logic port_two_led_a_out,
  output logic port_two_led_a_oe,
  output logic port_two_led_b_out,
  // eeprom pins
  output logic eeprom_select,
  output logic eeprom_serial_clock,
  input wire logic eeprom_serial_data_in,
  output logic eeprom_serial_data_out,
  output logic eeprom_serial_data_oe
);
  import pls_pkg::*;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    pls_led_ctrl_t [1:0] ctrl;
    logic strapped;
    logic [1:0] width;
    logic order, ee_pres, rsvd_ok, ee_start;
    logic [24:0] blink_cnt;
    logic phase;
    logic [1:0][1:0] hold;
    logic [3:0] led_out;
    logic [2:0] led_oe;
    logic [`PLS_EE_WORDS-1:0][15:0] words;
  } pls_st_t;
  pls_st_t st, next_st;
  logic [1:0] on_a, on_b;
  logic blink_tick, req, wr;
  logic ee_busy, ee_done, ee_wv;
  logic [2:0] ee_idx;
  logic [15:0] ee_word;
  assign blink_tick = st.blink_cnt == 25'(BLINK_HALF_CYC - 1);
  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && st.ack && wb_we_i;

  pls_ee_reader u_ee (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(st.ee_start),
    .busy(ee_busy),
    .done(ee_done),
    .word_valid(ee_wv),
    .word_idx(ee_idx),
    .word(ee_word),
    .eeprom_select(eeprom_select),
    .eeprom_serial_clock(eeprom_serial_clock),
    .data_out(eeprom_serial_data_out),
    .data_oe(eeprom_serial_data_oe),
    .data_in(eeprom_serial_data_in)
  );

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_port
      logic blink, bfun;
      pls_led_ctrl_t c;
      assign c = st.ctrl[gp];
      assign blink = (st.hold[gp] != 2'h0) && st.phase;
      assign bfun = (c.bsel == PLS_B_SPEED) ? speed_100[gp] :
                    (c.bsel == PLS_B_DUPLEX) ? full_duplex[gp] :
                    (c.bsel == PLS_B_LINK) ? link_up[gp] : blink;
      // pin a shows combined link/activity: solid with link, dark phases while traffic
      assign on_a[gp] = (c.mode == 3'h0) ? (link_up[gp] && !blink) : c.man_a;
      assign on_b[gp] = (c.mode == 3'h0) ? bfun : c.man_b;
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.ack = req && !st.ack;
    next_st.ee_start = 1'b0;
    if (req && !st.ack) begin
      next_st.dat = 32'h0;
      if (wb_adr_i[7:5] == `PLS_EE_WIN) begin
        next_st.dat[15:0] = st.words[wb_adr_i[4:2]];
      end else begin
        case ({wb_adr_i[7:2], 2'h0})
          `PLS_OFS_P1_LED, `PLS_OFS_P2_LED: begin
            next_st.dat[`PLS_LED_MODE_HI:`PLS_LED_MODE_LO] =
              st.ctrl[wb_adr_i[7:2] == `PLS_OFS_P2_LED >> 2].mode;
            next_st.dat[`PLS_LED_BSEL_HI:`PLS_LED_BSEL_LO] =
              st.ctrl[wb_adr_i[7:2] == `PLS_OFS_P2_LED >> 2].bsel;
            next_st.dat[`PLS_LED_MAN_B] = st.ctrl[wb_adr_i[7:2] == `PLS_OFS_P2_LED >> 2].man_b;
            next_st.dat[`PLS_LED_MAN_A] = st.ctrl[wb_adr_i[7:2] == `PLS_OFS_P2_LED >> 2].man_a;
          end
          `PLS_OFS_CHIP_CFG: begin
            next_st.dat[`PLS_CFG_WIDTH_HI:`PLS_CFG_WIDTH_LO] = st.width;
            next_st.dat[`PLS_CFG_ORDER] = st.order;
            next_st.dat[`PLS_CFG_EE_PRES] = st.ee_pres;
            next_st.dat[`PLS_CFG_RSVD_OK] = st.rsvd_ok;
          end
          `PLS_OFS_EE_STAT: begin
            next_st.dat[`PLS_ST_BUSY] = ee_busy;
            next_st.dat[`PLS_ST_DONE] = ee_done;
          end
          default: next_st.dat = 32'h0;
        endcase
      end
    end
    // writes take effect on the edge where the master sees ack
    if (wr && ({wb_adr_i[7:2], 2'h0} == `PLS_OFS_P1_LED ||
               {wb_adr_i[7:2], 2'h0} == `PLS_OFS_P2_LED)) begin
      if (wb_sel_i[0]) begin
        next_st.ctrl[wb_adr_i[7:2] == `PLS_OFS_P2_LED >> 2].bsel =
          pls_bsel_t'(wb_dat_i[`PLS_LED_BSEL_HI:`PLS_LED_BSEL_LO]);
        next_st.ctrl[wb_adr_i[7:2] == `PLS_OFS_P2_LED >> 2].man_b = wb_dat_i[`PLS_LED_MAN_B];
        next_st.ctrl[wb_adr_i[7:2] == `PLS_OFS_P2_LED >> 2].man_a = wb_dat_i[`PLS_LED_MAN_A];
      end
      if (wb_sel_i[1]) begin
        next_st.ctrl[wb_adr_i[7:2] == `PLS_OFS_P2_LED >> 2].mode =
          wb_dat_i[`PLS_LED_MODE_HI:`PLS_LED_MODE_LO];
      end
    end
    // straps: caught one cycle after release, pins stay inputs until then
    if (power_down) begin
      next_st.strapped = 1'b0;
    end else if (!st.strapped) begin
      next_st.strapped = 1'b1;
      next_st.width = port_one_led_a_in ? `PLS_WIDTH_16 : `PLS_WIDTH_8;
      next_st.order = port_two_led_a_in;
      next_st.rsvd_ok = port_one_led_b_in;
      next_st.ee_pres = eeprom_present_strap;
      next_st.ee_start = eeprom_present_strap;
    end
    // slow blink clock; a burst keeps blinking for one full period
    next_st.blink_cnt = blink_tick ? 25'h0 : st.blink_cnt + 25'h1;
    if (blink_tick)
      next_st.phase = !st.phase;
    for (int i = 0; i < 2; i++) begin
      if (activity[i])
        next_st.hold[i] = `PLS_ACT_HOLD;
      else if (blink_tick && st.hold[i] != 2'h0)
        next_st.hold[i] = st.hold[i] - 2'h1;
    end
    if (ee_wv)
      next_st.words[ee_idx] = ee_word;
    next_st.led_oe = {3{st.strapped && !power_down}};
    next_st.led_out = st.strapped ? ~{on_b[1], on_a[1], on_b[0], on_a[0]} : 4'hF;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st <= '0;
      st.led_out <= 4'hF;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign port_one_led_a_out = st.led_out[0];
  assign port_one_led_b_out = st.led_out[1];
  assign port_two_led_a_out = st.led_out[2];
  assign port_two_led_b_out = st.led_out[3];
  assign port_one_led_a_oe = st.led_oe[0];
  assign port_one_led_b_oe = st.led_oe[1];
  assign port_two_led_a_oe = st.led_oe[2];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_led_active_low: assert property ((st.strapped && st.ctrl[0].mode != 3'h0 &&
    st.ctrl[0].man_a) [*2] |-> !port_one_led_a_out)
    else $error("manual on did not drive port one pin a low");
  chk_auto_port_one: assert property ((st.strapped && st.ctrl[0].mode == 3'h0 &&
    link_up[0] && st.hold[0] == 2'h0) [*2] |-> !port_one_led_a_out)
    else $error("port one auto link led not lit");
  chk_auto_port_two: assert property ((st.strapped && st.ctrl[1].mode == 3'h0 &&
    !link_up[1]) [*2] |-> port_two_led_a_out)
    else $error("port two auto led lit without link");
  chk_manual_takeover: assert property ((wr && wb_adr_i == `PLS_OFS_P1_LED &&
    wb_sel_i == 4'hF && wb_dat_i[14:12] != 3'h0 && wb_dat_i[0] && st.strapped && !power_down)
    ##1 (st.strapped && !power_down) |=> !port_one_led_a_out)
    else $error("software led control not applied");
  chk_speed_led: assert property ((st.strapped && st.ctrl[0].mode == 3'h0 &&
    st.ctrl[0].bsel == PLS_B_SPEED) [*2] |-> port_one_led_b_out == !$past(speed_100[0]))
    else $error("speed led wrong");
  chk_duplex_led: assert property ((st.strapped && st.ctrl[1].mode == 3'h0 &&
    st.ctrl[1].bsel == PLS_B_DUPLEX) [*2] |-> port_two_led_b_out == !$past(full_duplex[1]))
    else $error("duplex led wrong");
  chk_strap_width: assert property ($rose(st.strapped) |->
    st.width == ($past(port_one_led_a_in) ? `PLS_WIDTH_16 : `PLS_WIDTH_8))
    else $error("bus width strap latched wrong");
  chk_strap_order: assert property ($rose(st.strapped) |->
    st.order == $past(port_two_led_a_in))
    else $error("byte order strap latched wrong");
  chk_pins_released: assert property (!st.strapped |=>
    !port_one_led_a_oe && !port_two_led_a_oe && !port_one_led_b_oe)
    else $error("strap pins driven before latch");
  chk_restrap_pd: assert property (power_down |=> !st.strapped ##1 !port_one_led_a_oe)
    else $error("power-down did not restrap");
  chk_act_hold: assert property (activity[0] |=> st.hold[0] == `PLS_ACT_HOLD)
    else $error("activity blink not armed");
  chk_ee_clock_sel: assert property (eeprom_serial_clock |-> eeprom_select)
    else $error("eeprom clock outside select");
  chk_wb_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  cov_manual: cover property (wr && wb_dat_i[14:12] != 3'h0);
  cov_blink: cover property (st.hold[0] != 2'h0 && blink_tick);
  cov_ee_done: cover property ($rose(ee_done));
  cov_restrap: cover property (power_down ##1 !power_down ##2 st.strapped);
endmodule
`default_nettype wire

// ===== verif/pls_board.sv
// board model: led pins with strap pulls, and a read-only serial eeprom
// assumes the block drives command bits on falling sk and samples data on rising sk
`timescale 1ns/1ps
`default_nettype none
module pls_board (
  // strap pulls
  input wire logic width_pull,
  input wire logic order_pull,
  input wire logic rsvd_pull,
  // led pins, index 0 port one a, 1 port one b, 2 port two a
  input wire logic [2:0] led_out,
  input wire logic [2:0] led_oe,
  output logic [2:0] led_pin,
  // eeprom pins
  input wire logic eeprom_select,
  input wire logic eeprom_serial_clock,
  input wire logic data_out,
  input wire logic data_oe,
  output logic data_in
);
  int rises = 0;
  logic [8:0] cmd = 9'h000;
  logic drv = 1'b0;
  logic bitv = 1'b0;
  logic [15:0] word;
  // an undriven pin sits at its pull level
  assign led_pin = (led_oe & led_out) | (~led_oe & {order_pull, rsvd_pull, width_pull});
  assign word = {4'h9, 1'b0, cmd[2:0], ~cmd[2:0], 5'h15};
  // the data line has a pull-down, so a released line reads low
  assign data_in = data_oe ? data_out : (drv & eeprom_select & bitv);
  always @(posedge eeprom_serial_clock or negedge eeprom_select) begin
    if (!eeprom_select) begin
      rises <= 0;
    end else begin
      rises <= rises + 1;
      if (rises < 9) cmd <= {cmd[7:0], data_out};
    end
  end
  always @(negedge eeprom_serial_clock) begin
    drv <= (rises >= 9) && (rises < 25);
    if ((rises >= 9) && (rises < 25)) bitv <= word[24 - rises];
  end
endmodule
`default_nettype wire

// ===== verif/pls_top_test.sv
// bench for the led/strap block: wishbone tasks, strap resets, led and eeprom checks
// assumes pls_board as the far side and a short blink period
`timescale 1ns/1ps
`default_nettype none
module pls_top_test;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [1:0] link_up = 2'h0, activity = 2'h0, speed_100 = 2'h0, full_duplex = 2'h0;
  logic power_down = 1'b0, ee_strap = 1'b0, width_pull = 1'b1, order_pull = 1'b1;
  logic rsvd_pull = 1'b1;
  logic ack, p2b, ee_sel, ee_sk, d_out, d_oe, d_in;
  logic [2:0] led_out, led_oe, led_pin;
  int fails = 0, checks_done = 0, cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  pls_top #(.BLINK_HALF_CYC(8)) dut (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .link_up(link_up), .activity(activity),
    .speed_100(speed_100), .full_duplex(full_duplex), .power_down(power_down),
    .eeprom_present_strap(ee_strap), .port_one_led_a_in(led_pin[0]),
    .port_one_led_a_out(led_out[0]), .port_one_led_a_oe(led_oe[0]),
    .port_one_led_b_in(led_pin[1]), .port_one_led_b_out(led_out[1]),
    .port_one_led_b_oe(led_oe[1]), .port_two_led_a_in(led_pin[2]),
    .port_two_led_a_out(led_out[2]), .port_two_led_a_oe(led_oe[2]),
    .port_two_led_b_out(p2b), .eeprom_select(ee_sel), .eeprom_serial_clock(ee_sk),
    .eeprom_serial_data_in(d_in), .eeprom_serial_data_out(d_out), .eeprom_serial_data_oe(d_oe));
  pls_board board (.width_pull(width_pull), .order_pull(order_pull), .rsvd_pull(rsvd_pull),
    .led_out(led_out), .led_oe(led_oe), .led_pin(led_pin), .eeprom_select(ee_sel),
    .eeprom_serial_clock(ee_sk), .data_out(d_out), .data_oe(d_oe), .data_in(d_in));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // called just after a rising edge; holds the request until ack is sampled
  task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    // a slave that never answers counts once and the request is dropped
    if (ack !== 1'b1) fails++;
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic do_reset(input logic w, input logic o, input logic e);
    width_pull <= w; order_pull <= o; ee_strap <= e;
    resetn <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check({29'h0, led_oe}, 32'h0);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({29'h0, led_oe}, 32'h7);
    wb_io(1'b0, 8'hD8, 32'h0);
    check(rd & 32'h6C1, {o, e, 1'b0, w, ~w, 5'h0, 1'b1});
  endtask
  function automatic logic [1:0] pins(input int p);
    return p ? {led_pin[2], p2b} : {led_pin[0], led_pin[1]};
  endfunction
  always @(posedge clk_sys) begin
    cycles++;
    // the eeprom load alone takes about 83k cycles
    if (cycles == 95000) begin
      fails++;
      test_done;
    end
  end
  initial begin
    int n, lo, hi;
    logic v;
    logic [2:0] m;
    logic [1:0] pv;
    do_reset(1'b0, 1'b1, 1'b1);
    $display("test straps done");
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 3; b++) begin
        wb_io(1'b1, p ? 8'h84 : 8'h6C, b << 2);
        for (int k = 0; k < 2; k++) begin
          v = k[0];
          link_up[p] <= v; speed_100[p] <= v; full_duplex[p] <= ~v;
          repeat (4) @(posedge clk_sys);
          check(pins(p), {~v, (b == 1) ? v : ~v});
        end
      end
      for (int k = 1; k < 8; k++) begin
        m = k[2:0];
        wb_io(1'b1, p ? 8'h84 : 8'h6C, {17'h0, m, 10'h0, m[1:0]});
        repeat (3) @(posedge clk_sys);
        check(pins(p), {~m[0], ~m[1]});
      end
      wb_io(1'b1, p ? 8'h84 : 8'h6C, 32'hC);
      activity[p] <= 1'b1;
      @(posedge clk_sys);
      activity[p] <= 1'b0;
      lo = 0; hi = 0;
      repeat (40) @(posedge clk_sys) begin
        pv = pins(p);
        lo += !pv[0];
        hi += pv[1];
      end
      check(lo != 0, 1);
      check(hi != 0, 1);
      repeat (80) @(posedge clk_sys);
      check(pins(p), 2'b01);
    end
    $display("test leds done");
    n = 0;
    do begin
      repeat (200) @(posedge clk_sys);
      wb_io(1'b0, 8'hDC, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 450);
    check(rd[1:0], 2'b10);
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      wb_io(1'b0, 8'hE0 + 8'(i * 4), 32'h0);
      check(rd & 32'hFFFF, {16'h0, 4'h9, 1'b0, m, ~m, 5'h15});
    end
    $display("test eeprom done");
    do_reset(1'b1, 1'b0, 1'b0);
    power_down <= 1'b1;
    width_pull <= 1'b0; order_pull <= 1'b1;
    repeat (5) @(posedge clk_sys);
    power_down <= 1'b0;
    repeat (5) @(posedge clk_sys);
    wb_io(1'b0, 8'hD8, 32'h0);
    check(rd & 32'h4C1, 32'h441);
    $display("test restrap done");
    test_done;
  end
endmodule
`default_nettype wire
